// file: pmsc_power_ctrl.sv
// Overview of operation
// - normal state clocks core and peripherals
// - idle halts core, any interrupt resumes
// - suspend stops clocks, oscillators; normal bias
// - snooze stops clocks, oscillators; low bias
// - sleep wakes on listed events; timers run
// - stop powers down, exits on any reset
// - shutdown exits only on pin/power reset
// - unused peripheral clocks gated off
// - reset clock is 24.5 MHz divided by 8
// - six clock source choices offered
// - divider by power of two, 1 to 128
// - optional 1.5x prescale on fast oscillators
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pmsc_power_ctrl #(
	parameter int SETTLE_CYCLES = pmsc_pkg::OSC_SETTLE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic any_irq,
	input wire logic t4_event,
	input wire logic spi_activity,
	input wire logic i2c_slave_activity,
	input wire logic port_match_pin,
	input wire logic cmp0_pin,
	input wire logic [3:0] config_logic_unit_irq,
	input wire logic other_reset_pin,
	input wire logic osc24_tick,
	input wire logic osc72_tick,
	input wire logic lf_tick,
	input wire logic ext_tick,
	output logic core_clk_en,
	output logic [7:0] periph_clk_en,
	output logic hf_osc_24m_en,
	output logic hf_osc_72m_en,
	output logic lf_timer_run,
	output logic reg_low_bias,
	output logic power_off,
	output logic pin_hold,
	output logic system_clock_tick
);
	import pmsc_pkg::*;

	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	pmsc_state_t state_reg; // power mode
	pmsc_state_t state_next;
	logic [1:0] pwr_first_reg; // idle, stop bits
	logic [1:0] pwr_second_reg; // suspend, snooze bits
	logic stop_depth_reg; // 1 selects shutdown
	logic [2:0] clk_src_reg; // system clock source
	logic [2:0] div_exp_reg; // divider exponent
	logic pre24_reg; // 1.5x on 24.5 MHz
	logic pre72_reg; // 1.5x on 72 MHz
	logic [7:0] periph_en_reg; // peripheral in use
	logic [3:0] wake_cfg_reg; // logic unit wake enables
	logic snooze_reg; // sleep is snooze
	logic [2:0] pm_sync1, pm_sync2; // port match, cmp0, reset
	logic cmp0_last; // for falling edge
	logic osc_stable; // oscillator settled
	logic wake_start; // settle timer kick
	logic wake_any; // any sleep wake event
	logic soft_rst; // other reset in stop
	logic wr_en, rd_setup; // bus strobes
	logic wr_first, wr_second; // mode writes
	logic src_tick, pre_en; // divider input
	logic [31:0] rd_mux; // read data
	logic rd_hit; // mapped address

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// two flops for port match, comparator, reset pin
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pm_sync1 <= 3'h0;
			pm_sync2 <= 3'h0;
			cmp0_last <= 1'b0;
		end
		else
		begin
			pm_sync1 <= {other_reset_pin, cmp0_pin, port_match_pin};
			pm_sync2 <= pm_sync1;
			cmp0_last <= pm_sync2[1];
		end
	end

	// sleep wake sources
	assign wake_any = t4_event || spi_activity || i2c_slave_activity
		|| pm_sync2[0] || (cmp0_last && !pm_sync2[1])
		|| ((config_logic_unit_irq & wake_cfg_reg) != 4'h0);
	assign soft_rst = (state_reg == PM_STOP) && pm_sync2[2];

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	assign wr_en = psel && penable && pwrite && pready;
	assign rd_setup = psel && !penable;
	assign wr_first = wr_en && (paddr == OFF_PWR_FIRST);
	assign wr_second = wr_en && (paddr == OFF_PWR_SECOND);

	// read mux over mapped words
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (paddr)
			OFF_PWR_FIRST: rd_mux[1:0] = pwr_first_reg;
			OFF_PWR_SECOND: rd_mux[1:0] = pwr_second_reg;
			OFF_REG_CTRL: rd_mux[BIT_STOP_DEPTH] = stop_depth_reg;
			OFF_CLK_SEL:
			begin
				rd_mux[2:0] = clk_src_reg;
				rd_mux[6:4] = div_exp_reg;
				rd_mux[BIT_PRE_24M] = pre24_reg;
				rd_mux[BIT_PRE_72M] = pre72_reg;
			end
			OFF_PERIPH_EN: rd_mux[7:0] = periph_en_reg;
			OFF_WAKE_CFG: rd_mux[3:0] = wake_cfg_reg;
			OFF_STATUS:
			begin
				rd_mux[ST_BIT_IDLE] = (state_reg == PM_IDLE);
				rd_mux[ST_BIT_SLEEP] = (state_reg == PM_SLEEP);
				rd_mux[ST_BIT_WAKE] = (state_reg == PM_WAKE);
				rd_mux[ST_BIT_STABLE] = osc_stable;
				rd_mux[ST_BIT_SNOOZE] = snooze_reg;
			end
			default: rd_hit = 1'b0; // unmapped reads zero, error
		endcase
	end

	// answer in the access cycle, no wait states
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end
		else
		begin
			pready <= 1'b1;
			if (rd_setup)
			begin
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr <= !rd_hit;
			end
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	// clock selection, reload on reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_src_reg <= RST_CLK_SRC;
			div_exp_reg <= RST_DIV_EXP;
			pre24_reg <= 1'b0;
			pre72_reg <= 1'b0;
		end
		else if (soft_rst)
		begin
			clk_src_reg <= RST_CLK_SRC;
			div_exp_reg <= RST_DIV_EXP;
			pre24_reg <= 1'b0;
			pre72_reg <= 1'b0;
		end
		else if (wr_en && paddr == OFF_CLK_SEL)
		begin
			clk_src_reg <= (pwdata[2:0] > SRC_EXT_XTAL) ? clk_src_reg : pwdata[2:0];
			div_exp_reg <= pwdata[6:4];
			pre24_reg <= pwdata[BIT_PRE_24M];
			pre72_reg <= pwdata[BIT_PRE_72M];
		end
	end

	// regulator, peripheral and wake settings
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stop_depth_reg <= 1'b0;
			periph_en_reg <= RST_PERIPH_EN;
			wake_cfg_reg <= RST_WAKE_CFG;
		end
		else if (soft_rst)
		begin
			stop_depth_reg <= 1'b0;
			periph_en_reg <= RST_PERIPH_EN;
			wake_cfg_reg <= RST_WAKE_CFG;
		end
		else if (wr_en)
		begin
			if (paddr == OFF_REG_CTRL)
				stop_depth_reg <= pwdata[BIT_STOP_DEPTH];
			if (paddr == OFF_PERIPH_EN)
				periph_en_reg <= pwdata[7:0];
			if (paddr == OFF_WAKE_CFG)
				wake_cfg_reg <= pwdata[3:0];
		end
	end

	// mode bits: set by write, cleared on the return to the normal state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwr_first_reg <= 2'h0;
			pwr_second_reg <= 2'h0;
		end
		else
		begin
			if (wr_first)
				pwr_first_reg <= pwdata[1:0]; // write wins
			else if (state_next == PM_NORMAL)
				pwr_first_reg <= 2'h0;
			if (wr_second)
				pwr_second_reg <= pwdata[1:0];
			else if (state_next == PM_NORMAL)
				pwr_second_reg <= 2'h0;
		end
	end

	// ----------------------------------------
	// power mode state machine
	// ----------------------------------------
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			PM_NORMAL:
			begin
				if (wr_first && pwdata[BIT_STOP])
					state_next = stop_depth_reg ? PM_SHUTDOWN : PM_STOP;
				else if (wr_second && (pwdata[BIT_SNOOZE] || pwdata[BIT_SUSPEND]))
					state_next = PM_SLEEP;
				else if (wr_first && pwdata[BIT_IDLE])
					state_next = PM_IDLE;
			end
			PM_IDLE:
				if (any_irq)
					state_next = PM_NORMAL;
			PM_SLEEP:
				if (wake_any)
					state_next = PM_WAKE;
			PM_WAKE:
				if (osc_stable && !wake_start)
					state_next = PM_NORMAL;
			PM_STOP:
				if (soft_rst)
					state_next = PM_NORMAL;
			PM_SHUTDOWN:
				state_next = PM_SHUTDOWN;
			default: state_next = PM_NORMAL;
		endcase
	end

	// state and sleep flavour
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= PM_NORMAL;
			snooze_reg <= 1'b0;
			wake_start <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			wake_start <= (state_reg == PM_SLEEP) && wake_any;
			if (state_reg == PM_NORMAL && state_next == PM_SLEEP)
				snooze_reg <= pwdata[BIT_SNOOZE];
		end
	end

	// outputs follow the next state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_clk_en <= 1'b1;
			periph_clk_en <= 8'h00;
			hf_osc_24m_en <= 1'b1;
			hf_osc_72m_en <= 1'b1;
			lf_timer_run <= 1'b1;
			reg_low_bias <= 1'b0;
			power_off <= 1'b0;
			pin_hold <= 1'b0;
		end
		else
		begin
			core_clk_en <= (state_next == PM_NORMAL);
			periph_clk_en <= (state_next == PM_NORMAL || state_next == PM_IDLE)
				? periph_en_reg : 8'h00;
			hf_osc_24m_en <= (state_next != PM_SLEEP) && (state_next != PM_STOP)
				&& (state_next != PM_SHUTDOWN);
			hf_osc_72m_en <= (state_next != PM_SLEEP) && (state_next != PM_STOP)
				&& (state_next != PM_SHUTDOWN);
			lf_timer_run <= (state_next != PM_STOP) && (state_next != PM_SHUTDOWN);
			reg_low_bias <= (state_next == PM_SLEEP) && ((state_reg == PM_SLEEP)
				? snooze_reg : pwdata[BIT_SNOOZE]);
			power_off <= (state_next == PM_STOP) || (state_next == PM_SHUTDOWN);
			pin_hold <= (state_next == PM_STOP) || (state_next == PM_SHUTDOWN);
		end
	end

	// ----------------------------------------
	// clock source and divider
	// ----------------------------------------
	// source select, stopped 24.5 and 72 MHz oscillators give no ticks
	always_comb
	begin
		src_tick = 1'b0;
		pre_en = 1'b0;
		case (clk_src_reg)
			SRC_HF_24M:
			begin
				src_tick = osc24_tick && hf_osc_24m_en;
				pre_en = pre24_reg;
			end
			SRC_HF_72M:
			begin
				src_tick = osc72_tick && hf_osc_72m_en;
				pre_en = pre72_reg;
			end
			SRC_LF_80K: src_tick = lf_tick;
			SRC_EXT_RC, SRC_EXT_CMOS, SRC_EXT_XTAL: src_tick = ext_tick;
			default: src_tick = 1'b0;
		endcase
	end

	pmsc_clk_div u_div (
		.clk(pclk),
		.rst_n(presetn),
		.src_tick(src_tick),
		.pre_en(pre_en),
		.div_exp(div_exp_reg),
		.tick_out(system_clock_tick)
	);

	pmsc_settle_timer #(
		.CYCLES(SETTLE_CYCLES)
	) u_settle (
		.clk(pclk),
		.rst_n(presetn),
		.start(wake_start),
		.stable(osc_stable)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_normal_run: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == PM_NORMAL && $past(state_reg) == PM_NORMAL) |-> core_clk_en)
		else $error("core clock off in normal state");
	a_idle_core: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == PM_IDLE) |-> (!core_clk_en && periph_clk_en == periph_en_reg))
		else $error("idle clocking wrong");
	a_idle_wake: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == PM_IDLE && any_irq) |=> (state_reg == PM_NORMAL && core_clk_en))
		else $error("interrupt did not end idle");
	a_sleep_osc: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == PM_SLEEP) |-> (!hf_osc_24m_en && !hf_osc_72m_en && !core_clk_en
		&& reg_low_bias == snooze_reg))
		else $error("sleep oscillators or bias wrong");
	a_sleep_wake: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == PM_SLEEP && spi_activity) |=> (state_reg == PM_WAKE && hf_osc_24m_en))
		else $error("sleep did not wake");
	a_wake_settle: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(state_reg == PM_WAKE) |-> (state_reg == PM_WAKE)[*2] ##[0:1000]
		(state_reg == PM_NORMAL && pwr_second_reg == 2'h0))
		else $error("wake did not settle and clear mode");
	a_stop_power: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == PM_STOP) |-> (power_off && pin_hold && !core_clk_en))
		else $error("stop not powered down");
	a_shut_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == PM_SHUTDOWN) |=> (state_reg == PM_SHUTDOWN && power_off))
		else $error("shutdown left without reset");
	a_mode_prio: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == PM_NORMAL && wr_first && pwdata[BIT_STOP] && pwdata[BIT_IDLE])
		|=> (state_reg == PM_STOP || state_reg == PM_SHUTDOWN))
		else $error("stop did not win over idle");
	a_reset_clock: assert property (@(posedge pclk)
		$rose(presetn) |-> (clk_src_reg == SRC_HF_24M && div_exp_reg == 3'h3))
		else $error("reset clock setting wrong");
endmodule : pmsc_power_ctrl
`default_nettype wire

// file: pmsc_pkg.sv
// ----------------------------------------
// power mode and system clock constants
// ----------------------------------------
package pmsc_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_PWR_FIRST = 8'h00;
	localparam logic [7:0] OFF_PWR_SECOND = 8'h04;
	localparam logic [7:0] OFF_REG_CTRL = 8'h08;
	localparam logic [7:0] OFF_CLK_SEL = 8'h0c;
	localparam logic [7:0] OFF_PERIPH_EN = 8'h10;
	localparam logic [7:0] OFF_WAKE_CFG = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	// field positions
	localparam int BIT_IDLE = 0;
	localparam int BIT_STOP = 1;
	localparam int BIT_SUSPEND = 0;
	localparam int BIT_SNOOZE = 1;
	localparam int BIT_STOP_DEPTH = 0;
	localparam int BIT_PRE_24M = 8;
	localparam int BIT_PRE_72M = 9;
	localparam int ST_BIT_IDLE = 0;
	localparam int ST_BIT_SLEEP = 1;
	localparam int ST_BIT_WAKE = 2;
	localparam int ST_BIT_STABLE = 3;
	localparam int ST_BIT_SNOOZE = 4;
	// clock source codes
	localparam logic [2:0] SRC_HF_24M = 3'h0;
	localparam logic [2:0] SRC_HF_72M = 3'h1;
	localparam logic [2:0] SRC_LF_80K = 3'h2;
	localparam logic [2:0] SRC_EXT_RC = 3'h3;
	localparam logic [2:0] SRC_EXT_CMOS = 3'h4;
	localparam logic [2:0] SRC_EXT_XTAL = 3'h5;
	// reset values: 24.5 MHz source divided by 8
	localparam logic [2:0] RST_CLK_SRC = SRC_HF_24M;
	localparam logic [2:0] RST_DIV_EXP = 3'h3;
	localparam logic [7:0] RST_PERIPH_EN = 8'h00;
	localparam logic [3:0] RST_WAKE_CFG = 4'h0;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int OSC_SETTLE_NS = 1000;
	localparam int OSC_SETTLE_CYCLES = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// power mode states
	typedef enum logic [2:0] {
		PM_NORMAL,
		PM_IDLE,
		PM_SLEEP,
		PM_WAKE,
		PM_STOP,
		PM_SHUTDOWN
	} pmsc_state_t;
endpackage : pmsc_pkg

// file: pmsc_settle_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// oscillator settle timer
// ----------------------------------------
module pmsc_settle_timer #(
	parameter int CYCLES = 100
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	output logic stable
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_reg; // cycles still to wait
	// reload on start, count down, flag when empty
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg <= '0;
			stable <= 1'b1;
		end
		else if (start)
		begin
			cnt_reg <= CW'(CYCLES);
			stable <= 1'b0;
		end
		else if (cnt_reg != '0)
		begin
			cnt_reg <= cnt_reg - 1'b1;
			stable <= (cnt_reg == CW'(1));
		end
	end
endmodule : pmsc_settle_timer
`default_nettype wire

// file: pmsc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// system clock divider, as an enable pulse
// ----------------------------------------
module pmsc_clk_div (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic src_tick,
	input wire logic pre_en,
	input wire logic [2:0] div_exp,
	output logic tick_out
);
	logic [1:0] pre_cnt_reg; // 1.5x prescale phase
	logic [6:0] div_cnt_reg; // power of two count
	logic pre_tick;
	logic [6:0] mask;
	// prescaler passes two ticks out of three
	assign pre_tick = src_tick && (!pre_en || pre_cnt_reg != 2'h2);
	assign mask = 7'((8'h01 << div_exp) - 8'h01);
	// prescale phase counter
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pre_cnt_reg <= 2'h0;
		else if (src_tick)
			pre_cnt_reg <= (pre_cnt_reg == 2'h2) ? 2'h0 : pre_cnt_reg + 2'h1;
	end
	// divide by 1..128 and emit one pulse
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_cnt_reg <= 7'h00;
			tick_out <= 1'b0;
		end
		else
		begin
			tick_out <= pre_tick && ((div_cnt_reg & mask) == mask);
			if (pre_tick)
				div_cnt_reg <= div_cnt_reg + 7'h01;
		end
	end
endmodule : pmsc_clk_div
`default_nettype wire

// file: pmsc_power_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench for power modes and system clock
// ----------------------------------------
module pmsc_power_ctrl_tb;
	import pmsc_pkg::*;
	localparam int SETTLE = 4; // short oscillator settle
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic any_irq = 1'b0;
	logic t4_event = 1'b0;
	logic spi_activity = 1'b0;
	logic i2c_slave_activity = 1'b0;
	logic port_match_pin = 1'b0;
	logic cmp0_pin = 1'b1; // idle high, falling edge wakes
	logic [3:0] config_logic_unit_irq = 4'h0;
	logic other_reset_pin = 1'b0;
	logic osc24_tick = 1'b1;
	logic osc72_tick = 1'b1;
	logic lf_tick = 1'b1;
	logic ext_tick = 1'b1;
	logic core_clk_en;
	logic [7:0] periph_clk_en;
	logic hf_osc_24m_en;
	logic hf_osc_72m_en;
	logic lf_timer_run;
	logic reg_low_bias;
	logic power_off;
	logic pin_hold;
	logic system_clock_tick;
	int err_count = 0;
	int check_count = 0;

	// ----------------------------------------
	// clock and device under test
	// ----------------------------------------
	always #5 pclk = ~pclk;

	pmsc_power_ctrl #(.SETTLE_CYCLES(SETTLE)) dut_u (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .any_irq(any_irq), .t4_event(t4_event),
		.spi_activity(spi_activity), .i2c_slave_activity(i2c_slave_activity),
		.port_match_pin(port_match_pin), .cmp0_pin(cmp0_pin),
		.config_logic_unit_irq(config_logic_unit_irq), .other_reset_pin(other_reset_pin),
		.osc24_tick(osc24_tick), .osc72_tick(osc72_tick), .lf_tick(lf_tick),
		.ext_tick(ext_tick), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
		.hf_osc_24m_en(hf_osc_24m_en), .hf_osc_72m_en(hf_osc_72m_en),
		.lf_timer_run(lf_timer_run), .reg_low_bias(reg_low_bias), .power_off(power_off),
		.pin_hold(pin_hold), .system_clock_tick(system_clock_tick)
	);

	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	// verdict and end of run
	task automatic tally_and_finish;
		if (err_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	// compare seen against expected
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			err_count++;
		end
	endtask : chk

	// a wait ran out of cycles
	task automatic hang;
		err_count++;
		tally_and_finish();
	endtask : hang

	// one apb transfer, setup then access until pready
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			hang();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic e;
		apb(a, 1'b1, d, rd, e);
	endtask : wr

	// register read and compare
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic e;
		apb(a, 1'b0, 32'h0, rd, e);
		chk(rd, exp);
	endtask : rd_chk

	// let n edges pass, then settle
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : wait_cyc

	// bounded wait for the core clock to return
	task automatic wait_core(output int n);
		n = 0;
		while (core_clk_en !== 1'b1 && n < 80)
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		if (core_clk_en !== 1'b1)
			hang();
	endtask : wait_core

	// count divided clock pulses over a window
	task automatic cnt_ticks(input int cyc, output int c);
		c = 0;
		repeat (cyc)
		begin
			@(posedge pclk);
			#1;
			if (system_clock_tick === 1'b1)
				c++;
		end
	endtask : cnt_ticks

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// reset values and an unmapped address
	task automatic t_reset;
		logic [31:0] rd;
		logic e;
		chk(core_clk_en, 1'b1);
		chk(periph_clk_en, 8'h00);
		rd_chk(OFF_CLK_SEL, 32'h0000_0030);
		rd_chk(OFF_PERIPH_EN, 32'h0);
		rd_chk(OFF_WAKE_CFG, 32'h0);
		rd_chk(OFF_STATUS, 32'h8);
		apb(8'h40, 1'b0, 32'h0, rd, e);
		chk({rd[30:0], e}, 32'h1);
		apb(8'h40, 1'b1, 32'hffff_ffff, rd, e);
		chk(e, 1'b1);
	endtask : t_reset

	// idle keeps peripherals, any interrupt resumes
	task automatic t_idle;
		int n;
		wr(OFF_PERIPH_EN, 32'ha5);
		wait_cyc(1);
		chk(periph_clk_en, 8'ha5);
		wr(OFF_PWR_FIRST, 32'h1);
		wait_cyc(4);
		chk(core_clk_en, 1'b0);
		chk(periph_clk_en, 8'ha5);
		rd_chk(OFF_STATUS, 32'h9);
		@(posedge pclk);
		any_irq <= 1'b1;
		@(posedge pclk);
		any_irq <= 1'b0;
		#1;
		wait_core(n);
		chk(n <= 3, 1'b1);
		chk(periph_clk_en, 8'ha5);
	endtask : t_idle

	// suspend or snooze, woken by one source
	task automatic t_sleep(input int src, input logic snooze);
		int n;
		wr(OFF_CLK_SEL, 32'h30);
		wr(OFF_WAKE_CFG, 32'hf);
		wr(OFF_PWR_SECOND, snooze ? 32'h3 : 32'h1);
		wait_cyc(2);
		chk(core_clk_en, 1'b0);
		chk(periph_clk_en, 8'h00);
		chk({hf_osc_24m_en, hf_osc_72m_en}, 2'b00);
		chk(reg_low_bias, snooze);
		chk(lf_timer_run, 1'b1);
		wait_cyc(4);
		chk(core_clk_en, 1'b0);
		rd_chk(OFF_STATUS, snooze ? 32'h1a : 32'h0a);
		@(posedge pclk);
		case (src)
			0: t4_event <= 1'b1;
			1: spi_activity <= 1'b1;
			2: i2c_slave_activity <= 1'b1;
			3: port_match_pin <= 1'b1;
			4: cmp0_pin <= 1'b0;
			default: config_logic_unit_irq <= 4'h4;
		endcase
		@(posedge pclk);
		t4_event <= 1'b0;
		spi_activity <= 1'b0;
		i2c_slave_activity <= 1'b0;
		config_logic_unit_irq <= 4'h0;
		#1;
		wait_core(n);
		chk(n >= SETTLE, 1'b1);
		chk({hf_osc_24m_en, reg_low_bias}, 2'b10);
		@(posedge pclk);
		port_match_pin <= 1'b0;
		cmp0_pin <= 1'b1;
		rd_chk(OFF_PWR_SECOND, 32'h0);
	endtask : t_sleep

	// stop or shutdown, then the reset that may end it
	task automatic t_stop(input logic deep);
		wr(OFF_PERIPH_EN, 32'h5a);
		wr(OFF_REG_CTRL, {31'h0, deep});
		wr(OFF_PWR_FIRST, 32'h3);
		wait_cyc(2);
		chk({power_off, pin_hold}, 2'b11);
		chk({lf_timer_run, core_clk_en}, 2'b00);
		@(posedge pclk);
		other_reset_pin <= 1'b1;
		wait_cyc(2);
		@(posedge pclk);
		other_reset_pin <= 1'b0;
		wait_cyc(6);
		chk(power_off, deep);
		if (deep)
		begin
			@(posedge pclk);
			presetn <= 1'b0;
			wait_cyc(2);
			@(posedge pclk);
			presetn <= 1'b1;
			wait_cyc(2);
		end
		chk({power_off, pin_hold}, 2'b00);
		chk(periph_clk_en, 8'h00);
	endtask : t_stop

	// source select, divider and prescalers
	task automatic t_clk;
		int c;
		cnt_ticks(256, c);
		chk(c, 32);
		for (int s = 0; s < 6; s++)
		begin
			wr(OFF_CLK_SEL, s);
			@(posedge pclk);
			osc24_tick <= (s == 0);
			osc72_tick <= (s == 1);
			lf_tick <= (s == 2);
			ext_tick <= (s >= 3);
			wait_cyc(3);
			cnt_ticks(16, c);
			chk(c, 16);
			@(posedge pclk);
			{osc24_tick, osc72_tick, lf_tick, ext_tick} <= ~{osc24_tick, osc72_tick, lf_tick, ext_tick};
			wait_cyc(3);
			cnt_ticks(16, c);
			chk(c, 0);
		end
		@(posedge pclk);
		{osc24_tick, osc72_tick, lf_tick, ext_tick} <= 4'hf;
		for (int e = 0; e < 8; e++)
		begin
			wr(OFF_CLK_SEL, e << 4);
			wait_cyc(3);
			cnt_ticks(256, c);
			chk(c, 256 >> e);
		end
		wr(OFF_CLK_SEL, 32'h100);
		wait_cyc(3);
		cnt_ticks(96, c);
		chk(c, 64);
		wr(OFF_CLK_SEL, 32'h201);
		wait_cyc(3);
		cnt_ticks(96, c);
		chk(c, 64);
	endtask : t_clk

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		wait_cyc(2);
		t_reset();
		t_idle();
		for (int k = 0; k < 6; k++)
			t_sleep(k, (k % 2) == 1);
		t_stop(1'b0);
		t_stop(1'b1);
		t_clk();
		tally_and_finish();
	end
endmodule : pmsc_power_ctrl_tb
`default_nettype wire
